/* include/fcs_pkg.sv */
// Purpose: Shared constants and types for the flash command sequencer.
// Assumes: 10 MHz system clock, byte-wide flash data, 12-bit register offsets.
// Notes:   Timing counts are derived from the printed maximum times.
`default_nettype none
package fcs_pkg;
  // Register offsets
  localparam logic [11:0] OFS_CTRL1    = 12'hfd0;
  localparam logic [11:0] OFS_COMMIT   = 12'hfd1;
  localparam logic [11:0] OFS_STANDBY  = 12'hfd2;
  localparam logic [11:0] OFS_PORTGATE = 12'hfd3;
  localparam logic [11:0] OFS_STATUS   = 12'hfd4;
  // Field positions and reset values
  localparam int          MODE_LSB       = 5;
  localparam logic [2:0]  MODE_ENABLE    = 3'h5;
  localparam logic [2:0]  MODE_DISABLE   = 3'h2;
  localparam logic [7:0]  COMMIT_KEY     = 8'hd5;
  localparam int          STANDBY_BIT    = 0;
  localparam int          GATE_SCLK_BIT  = 0;
  localparam int          GATE_OTHER_BIT = 1;
  localparam logic [7:0]  GATE_RESET     = 8'h80;
  localparam int          TOGGLE_BIT     = 6;
  // Command codes and sequence addresses
  localparam logic [7:0]  CMD_UNLOCK1  = 8'haa;
  localparam logic [7:0]  CMD_UNLOCK2  = 8'h55;
  localparam logic [7:0]  CMD_PROG     = 8'ha0;
  localparam logic [7:0]  CMD_ERASE    = 8'h80;
  localparam logic [7:0]  CMD_SECTOR   = 8'h30;
  localparam logic [7:0]  CMD_CHIP     = 8'h10;
  localparam logic [7:0]  CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0]  CMD_ID_EXIT  = 8'hf0;
  localparam logic [7:0]  CMD_SECURE   = 8'ha5;
  localparam logic [7:0]  SECURE_DATA  = 8'h00;
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;
  localparam logic [7:0]  SECURE_OFF   = 8'hff;
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'haaa;
  localparam logic [15:0] ADDR_SECURE  = 16'hff7f;
  localparam logic [15:0] ADDR_VENDOR  = 16'hf000;
  localparam logic [15:0] ADDR_FLASHID = 16'hf001;
  localparam logic [14:0] SECTOR_LAST  = 15'h0fff;
  localparam logic [14:0] ARRAY_LAST   = 15'h7fff;
  // Timing
  localparam int CLK_HZ       = 10_000_000;
  localparam int PROG_MAX_US  = 40;
  localparam int PROG_CYC     = PROG_MAX_US * (CLK_HZ / 1_000_000);
  localparam int ERASE_MAX_MS = 30;
  localparam int ERASE_CYC    = ERASE_MAX_MS * (CLK_HZ / 1_000);
  localparam int CNT_W        = 19;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_U1   = 4'h1,
    S_U2   = 4'h3,
    S_PROG = 4'h2,
    S_E1   = 4'h6,
    S_E2   = 4'h7,
    S_E3   = 4'h5,
    S_SEC  = 4'h4,
    S_BUSY = 4'hc
  } fcs_state_t;

  typedef enum logic [1:0] {
    OP_PROG   = 2'h0,
    OP_SECTOR = 2'h1,
    OP_CHIP   = 2'h2,
    OP_SECURE = 2'h3
  } fcs_op_t;
endpackage
`default_nettype wire

/* rtl/fcs_in_gate.sv */
// Purpose: Registered enable gate for a group of port inputs.
// Assumes: Inputs synchronous to the system clock.
// Notes:   A disabled input reads as zero, so no floating level reaches logic.
`default_nettype none
module fcs_in_gate #(
  parameter int W = 1
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  input  wire logic         i_en,
  input  wire logic [W-1:0] i_d,
  output var  logic [W-1:0] o_q
);
  if (W < 1) begin
    $error("fcs_in_gate: W must be at least 1");
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_q <= '0;
    end else begin
      o_q <= i_en ? i_d : '0;
    end
  end
endmodule
`default_nettype wire

/* rtl/fcs_top.sv */
// Purpose: Command-sequence front end of the on-chip flash array.
// Assumes: CPU bus cycles are one-cycle strobes; flash window is 0x8000-0xffff.
// Notes:   The array model lives here; erase walks one byte per clock.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`default_nettype none
module fcs_top
  import fcs_pkg::*;
#(
  parameter int         ERASE_CYCLES = ERASE_CYC,
  parameter int         PORT_W       = 8,
  parameter logic [7:0] VENDOR_CODE  = 8'h3c,  // Arbitrary value
  parameter logic [7:0] DEVICE_CODE  = 8'h5a   // Arbitrary value
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  // Register port
  input  wire logic [11:0]       i_reg_addr,
  input  wire logic [7:0]        i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output var  logic [7:0]        o_reg_rdata,
  // Flash access port
  input  wire logic [15:0]       i_fl_addr,
  input  wire logic [7:0]        i_fl_wdata,
  input  wire logic              i_fl_wr,
  input  wire logic              i_fl_rd,
  input  wire logic              i_fl_fetch,
  output var  logic [7:0]        o_fl_rdata,
  output var  logic              o_busy,
  output var  logic              o_exec_en,
  // Core context
  input  wire logic              i_exec_from_ram,
  input  wire logic              i_irq_taken,
  input  wire logic              i_vector_ram,
  output var  logic              o_vector_from_ram,
  output var  logic              o_standby_rst,
  // Operating modes
  input  wire logic              i_boot_mode,
  input  wire logic              i_parallel_mode,
  // Port inputs
  input  wire logic [PORT_W-1:0] i_port_in,
  input  wire logic              i_sclk_in,
  output var  logic [PORT_W-1:0] o_port_in,
  output var  logic              o_sclk_in
);
  localparam int PROG_BOUND = PROG_CYC;

  // Refused at elaboration: the busy counter cannot hold larger limits
  if (ERASE_CYCLES < 1 || ERASE_CYCLES >= (1 << CNT_W)) begin
    $error("fcs_top: bad ERASE_CYCLES");
  end
  if (PORT_W < 1) begin
    $error("fcs_top: PORT_W must be at least 1");
  end

  logic [7:0]       mem [0:32767];
  fcs_state_t       st_q;
  fcs_state_t       st_d;
  fcs_op_t          op_q;
  fcs_op_t          op_d;
  logic [2:0]       mode_pend_q;
  logic             exec_en_q;
  logic             stb_q;
  logic [7:0]       gate_q;
  logic             id_q;
  logic [7:0]       sec_q;
  logic             toggle_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] lim_q;
  logic [14:0]      walk_q;
  logic [14:0]      walk_end_q;
  logic             walk_done_q;
  logic             launch;
  logic             id_entry;
  logic             id_exit;
  logic             wr_ok;
  logic             at_u1;
  logic             at_u2;
  logic             done;
  logic             erasing;
  logic [7:0]       rd_byte;
  logic [7:0]       busy_byte;

  // Register writes: command-mode field takes effect only on the commit key
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      mode_pend_q <= MODE_DISABLE;
      exec_en_q   <= 1'b0;
    end else if (i_reg_wr && i_reg_addr == OFS_CTRL1) begin
      mode_pend_q <= i_reg_wdata[MODE_LSB+:3];
    end else if (i_reg_wr && i_reg_addr == OFS_COMMIT && i_reg_wdata == COMMIT_KEY) begin
      exec_en_q <= (mode_pend_q == MODE_ENABLE);
    end
  end

  // Interrupt clear wins over a simultaneous software write
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      stb_q <= 1'b0;
    end else if (i_irq_taken && !i_vector_ram) begin
      stb_q <= 1'b0;
    end else if (i_reg_wr && i_reg_addr == OFS_STANDBY && i_exec_from_ram) begin
      stb_q <= i_reg_wdata[STANDBY_BIT];
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_vector_from_ram <= 1'b0;
    end else if (i_irq_taken) begin
      o_vector_from_ram <= i_vector_ram;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_standby_rst <= 1'b0;
    end else begin
      o_standby_rst <= stb_q && (i_fl_rd || i_fl_wr || i_fl_fetch);
    end
  end

  // Gate register only exists in boot mode
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      gate_q <= GATE_RESET;
    end else if (i_reg_wr && i_reg_addr == OFS_PORTGATE && i_boot_mode) begin
      gate_q[GATE_OTHER_BIT] <= i_reg_wdata[GATE_OTHER_BIT];
      gate_q[GATE_SCLK_BIT]  <= i_reg_wdata[GATE_SCLK_BIT];
    end
  end

  // Read data stand for one cycle only
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (!i_reg_rd) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_addr == OFS_CTRL1) begin
      o_reg_rdata <= {mode_pend_q, 5'h00};
    end else if (i_reg_addr == OFS_PORTGATE) begin
      o_reg_rdata <= i_boot_mode ? gate_q : 8'h00;
    end else if (i_reg_addr == OFS_STATUS) begin
      o_reg_rdata <= {4'h0, o_busy, exec_en_q, id_q, stb_q};
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

  assign o_exec_en = exec_en_q;

  // Port input gating; the serial clock input has its own gate bit, GATE_SCLK_BIT, and its own instance
  fcs_in_gate #(.W(PORT_W)) u_gate_other (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_en      (!i_boot_mode || gate_q[GATE_OTHER_BIT]),
    .i_d       (i_port_in),
    .o_q       (o_port_in)
  );

  fcs_in_gate #(.W(1)) u_gate_sclk (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_en      (!i_boot_mode || gate_q[GATE_SCLK_BIT]),
    .i_d       (i_sclk_in),
    .o_q       (o_sclk_in)
  );

  // Command decoding
  assign wr_ok   = i_fl_wr && exec_en_q && (st_q != S_BUSY) && !stb_q;
  assign at_u1   = i_fl_addr[15] && (i_fl_addr[11:0] == ADDR_UNLOCK1);
  assign at_u2   = i_fl_addr[15] && (i_fl_addr[11:0] == ADDR_UNLOCK2);
  assign erasing = (op_q == OP_SECTOR) || (op_q == OP_CHIP);
  assign done    = walk_done_q && (cnt_q >= lim_q - CNT_W'(1));

  always_comb begin
    st_d     = st_q;
    op_d     = op_q;
    launch   = 1'b0;
    id_entry = 1'b0;
    id_exit  = 1'b0;
    if (st_q == S_BUSY) begin
      if (done) st_d = S_IDLE;
    end else if (wr_ok) begin
      st_d = S_IDLE;
      case (st_q)
        S_IDLE: begin
          if (at_u1 && i_fl_wdata == CMD_UNLOCK1) st_d = S_U1;
        end
        S_U1: begin
          if (at_u2 && i_fl_wdata == CMD_UNLOCK2) st_d = S_U2;
        end
        S_U2: begin
          if (at_u1 && i_fl_wdata == CMD_PROG) st_d = S_PROG;
          if (at_u1 && i_fl_wdata == CMD_ERASE) st_d = S_E1;
          if (at_u1 && i_fl_wdata == CMD_SECURE) st_d = S_SEC;
          if (at_u1 && i_fl_wdata == CMD_ID_ENTRY) id_entry = 1'b1;
        end
        S_PROG: begin
          st_d   = S_BUSY;
          op_d   = OP_PROG;
          launch = 1'b1;
        end
        S_E1: begin
          if (at_u1 && i_fl_wdata == CMD_UNLOCK1) st_d = S_E2;
        end
        S_E2: begin
          if (at_u2 && i_fl_wdata == CMD_UNLOCK2) st_d = S_E3;
        end
        S_E3: begin
          if (i_fl_addr[15] && i_fl_wdata == CMD_SECTOR && !i_parallel_mode) begin
            st_d   = S_BUSY;
            op_d   = OP_SECTOR;
            launch = 1'b1;
          end else if (at_u1 && i_fl_wdata == CMD_CHIP) begin
            st_d   = S_BUSY;
            op_d   = OP_CHIP;
            launch = 1'b1;
          end
        end
        S_SEC: begin
          if (i_fl_addr == ADDR_SECURE && i_fl_wdata == SECURE_DATA) begin
            st_d   = S_BUSY;
            op_d   = OP_SECURE;
            launch = 1'b1;
          end
        end
        default: st_d = S_IDLE;
      endcase
      // F0 is ordinary data in the program and security data cycles
      if (st_q != S_PROG && st_q != S_SEC && i_fl_wdata == CMD_ID_EXIT) begin
        st_d    = S_IDLE;
        id_exit = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_q   <= S_IDLE;
      op_q   <= OP_PROG;
      o_busy <= 1'b0;
    end else begin
      st_q   <= st_d;
      op_q   <= op_d;
      o_busy <= (st_d == S_BUSY);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      id_q <= 1'b0;
    end else if (id_exit) begin
      id_q <= 1'b0;
    end else if (id_entry) begin
      id_q <= 1'b1;
    end
  end

  // Security status follows the operation; chip erase clears it
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sec_q <= SECURE_OFF;
    end else if (launch && op_d == OP_SECURE) begin
      sec_q <= SECURE_DATA;
    end else if (launch && op_d == OP_CHIP) begin
      sec_q <= SECURE_OFF;
    end
  end

  // Busy timer: stays busy until both the timer and the erase walk are done
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
      lim_q <= CNT_W'(1);
    end else if (launch) begin
      cnt_q <= '0;
      lim_q <= (op_d == OP_SECTOR || op_d == OP_CHIP) ?
               CNT_W'(ERASE_CYCLES) : CNT_W'(PROG_CYC);
    end else if (st_q == S_BUSY && !done) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      walk_q      <= '0;
      walk_end_q  <= '0;
      walk_done_q <= 1'b1;
    end else if (launch) begin
      walk_q      <= (op_d == OP_SECTOR) ? {i_fl_addr[14:12], 12'h000} : 15'h0000;
      walk_end_q  <= (op_d == OP_SECTOR) ? ({i_fl_addr[14:12], 12'h000} | SECTOR_LAST)
                                         : ARRAY_LAST;
      walk_done_q <= (op_d == OP_PROG) || (op_d == OP_SECURE);
    end else if (st_q == S_BUSY && !walk_done_q) begin
      walk_q      <= walk_q + 15'h0001;
      walk_done_q <= (walk_q == walk_end_q);
    end
  end

  // Array writes; the array itself carries no reset
  always_ff @(posedge i_clk_sys) begin
    if (launch && op_d == OP_PROG) begin
      mem[i_fl_addr[14:0]] <= i_fl_wdata;
    end else if (st_q == S_BUSY && erasing && !walk_done_q) begin
      mem[walk_q] <= ERASED_BYTE;
    end
  end

  always_comb begin
    rd_byte               = mem[i_fl_addr[14:0]];
    busy_byte             = rd_byte;
    busy_byte[TOGGLE_BIT] = toggle_q;
  end

  // Toggle status: first read after launch shows one, then inverts per read
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      toggle_q <= 1'b0;
    end else if (launch) begin
      toggle_q <= 1'b1;
    end else if (st_q == S_BUSY && i_fl_rd && exec_en_q) begin
      toggle_q <= !toggle_q;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_fl_rdata <= 8'h00;
    end else if (i_fl_rd || i_fl_fetch) begin
      if (st_q == S_BUSY) begin
        o_fl_rdata <= busy_byte;
      end else if (id_q && i_fl_addr == ADDR_VENDOR) begin
        o_fl_rdata <= VENDOR_CODE;
      end else if (id_q && i_fl_addr == ADDR_FLASHID) begin
        o_fl_rdata <= DEVICE_CODE;
      end else if (id_q && i_fl_addr == ADDR_SECURE) begin
        o_fl_rdata <= sec_q;
      end else begin
        o_fl_rdata <= rd_byte;
      end
    end
  end

  // Checks
  stb_ram_only_a : assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_reg_wr && i_reg_addr == OFS_STANDBY && !i_exec_from_ram && !i_irq_taken)
    |=> $stable(stb_q)) else $error("standby bit changed by flash code");

  stb_reset_a : assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (stb_q && (i_fl_rd || i_fl_wr || i_fl_fetch)) |=> o_standby_rst)
    else $error("no standby reset on flash access");

  irq_clear_a : assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_irq_taken && !i_vector_ram) |=> (!stb_q && !o_vector_from_ram))
    else $error("standby not cleared on flash vector");

  irq_keep_a : assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_irq_taken && i_vector_ram && !(i_reg_wr && i_reg_addr == OFS_STANDBY))
    |=> ($stable(stb_q) && o_vector_from_ram)) else $error("standby changed on RAM vector");

  boot_gate_a : assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_boot_mode && !gate_q[GATE_OTHER_BIT]) |=> (o_port_in == '0))
    else $error("port input passed while gated");

  mcu_gate_a : assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    !i_boot_mode |=> (o_port_in == $past(i_port_in) && o_sclk_in == $past(i_sclk_in)))
    else $error("port input gated in normal mode");

  unlock_step_a : assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (st_q == S_IDLE && wr_ok && at_u1 && i_fl_wdata == CMD_UNLOCK1) |=> (st_q == S_U1))
    else $error("first unlock cycle not taken");

  sector_par_a : assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (st_q == S_E3 && i_parallel_mode && i_fl_wdata == CMD_SECTOR && !at_u1)
    |=> (st_q != S_BUSY)) else $error("sector erase in parallel mode");

  prog_time_a : assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (launch && op_d == OP_PROG) |=> o_busy ##[1:PROG_BOUND] !o_busy)
    else $error("byte program too long");

  busy_hold_a : assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (st_q == S_BUSY && !done) |=> (st_q == S_BUSY && $stable(op_q)))
    else $error("command accepted during operation");

  toggle_flip_a : assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (st_q == S_BUSY && i_fl_rd && exec_en_q && !launch)
    |=> (o_fl_rdata[TOGGLE_BIT] == $past(toggle_q) && toggle_q != $past(toggle_q)))
    else $error("toggle bit not inverted");

  disabled_a : assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (!exec_en_q && st_q == S_IDLE) |=> (st_q == S_IDLE))
    else $error("sequence advanced while disabled");

  first_one_a : assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    launch |=> toggle_q) else $error("first toggle read not one");
endmodule
`default_nettype wire

/* verif/fcs_cpu_model.sv */
// Purpose: CPU core model that issues flash bus write, read and fetch cycles.
// Assumes: One-cycle strobes launched by non-blocking assignment after a rising edge.
// Notes:   Released address and data lines show the inverse so stale sampling is caught.
`default_nettype none
module fcs_cpu_model
  import fcs_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic [7:0]  i_fl_rdata,
  output var  logic [15:0] o_fl_addr,
  output var  logic [7:0]  o_fl_wdata,
  output var  logic        o_fl_wr,
  output var  logic        o_fl_rd,
  output var  logic        o_fl_fetch
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_fl_addr  = 16'hffff;
    o_fl_wdata = 8'h00;
    o_fl_wr    = 1'b0;
    o_fl_rd    = 1'b0;
    o_fl_fetch = 1'b0;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] dt);
    @(posedge i_clk_sys);
    o_fl_addr  <= a;
    o_fl_wdata <= dt;
    o_fl_wr    <= 1'b1;
    @(posedge i_clk_sys);
    o_fl_wr    <= 1'b0;
    o_fl_addr  <= ~a;
    o_fl_wdata <= ~dt;
  endtask
  // Upper nibble 0xf on every sequence cycle, the recommended choice
  task automatic cmd(input logic [7:0] c);
    wr({4'hf, ADDR_UNLOCK1}, CMD_UNLOCK1);
    wr({4'hf, ADDR_UNLOCK2}, CMD_UNLOCK2);
    wr({4'hf, ADDR_UNLOCK1}, c);
  endtask
  task automatic rd(input logic [15:0] a, input logic f, output logic [7:0] dt);
    @(posedge i_clk_sys);
    o_fl_addr  <= a;
    o_fl_rd    <= !f;
    o_fl_fetch <= f;
    @(posedge i_clk_sys);
    o_fl_rd    <= 1'b0;
    o_fl_fetch <= 1'b0;
    o_fl_addr  <= ~a;
    #1;
    dt = i_fl_rdata;
  endtask
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Purpose: Self-checking bench for the flash command sequencer.
// Assumes: Short erase count, so erase time is set by the byte walk.
// Notes:   Random data and addresses come from a fixed seed.
`default_nettype none
module tb_top
  import fcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] VEND = 8'h3c;  // Arbitrary value
  localparam logic [7:0] DEVC = 8'h5a;  // Arbitrary value
  logic        clk, rst, rwr, rrd, xram, irq, vram, boot, par, sclk;
  logic        fwr, frd, ffe, busy, exen, vfr, srst, sclko;
  logic [11:0] radr;
  logic [7:0]  rwd, rrdat, frdat, fwd, pin, pout, d, pd;
  logic [15:0] fadr, a;
  int          n_errors, samples_checked, n;

  fcs_top #(.ERASE_CYCLES(8), .VENDOR_CODE(VEND), .DEVICE_CODE(DEVC)) u_fcs_top (
    .i_clk_sys(clk), .i_rst(rst), .i_reg_addr(radr), .i_reg_wdata(rwd), .i_reg_wr(rwr),
    .i_reg_rd(rrd), .o_reg_rdata(rrdat), .i_fl_addr(fadr), .i_fl_wdata(fwd),
    .i_fl_wr(fwr), .i_fl_rd(frd), .i_fl_fetch(ffe), .o_fl_rdata(frdat), .o_busy(busy),
    .o_exec_en(exen), .i_exec_from_ram(xram), .i_irq_taken(irq), .i_vector_ram(vram),
    .o_vector_from_ram(vfr), .o_standby_rst(srst), .i_boot_mode(boot),
    .i_parallel_mode(par), .i_port_in(pin), .i_sclk_in(sclk), .o_port_in(pout),
    .o_sclk_in(sclko));
  fcs_cpu_model u_fcs_cpu_model (.i_clk_sys(clk), .i_fl_rdata(frdat), .o_fl_addr(fadr),
    .o_fl_wdata(fwd), .o_fl_wr(fwr), .o_fl_rd(frd), .o_fl_fetch(ffe));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [7:0] b(input logic x);
    return {7'h0, x};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h, want %h", $time, g, e);
    end
  endtask
  task automatic rw(input logic [11:0] ad, input logic [7:0] dt);
    @(posedge clk);
    radr <= ad;
    rwd  <= dt;
    rwr  <= 1'b1;
    @(posedge clk);
    rwr  <= 1'b0;
  endtask
  task automatic rr(input logic [11:0] ad);
    @(posedge clk);
    radr <= ad;
    rrd  <= 1'b1;
    @(posedge clk);
    rrd  <= 1'b0;
    #1;
    d = rrdat;
  endtask
  task automatic fr(input logic [15:0] ad, input logic f);
    u_fcs_cpu_model.rd(ad, f, d);
  endtask
  task automatic gate(input logic [7:0] w, input logic [7:0] m, input logic s);
    rw(OFS_PORTGATE, w);
    pin  <= 8'($urandom);
    sclk <= 1'($urandom);
    repeat (3) @(posedge clk);
    #1;
    chk(pout, pin & m);
    chk(b(sclko), b(sclk & s));
  endtask
  // Second unlock, then the final code goes to the target address
  task automatic erase(input logic [15:0] ad, input logic [7:0] c);
    u_fcs_cpu_model.cmd(CMD_ERASE);
    u_fcs_cpu_model.wr({4'hf, ADDR_UNLOCK1}, CMD_UNLOCK1);
    u_fcs_cpu_model.wr({4'hf, ADDR_UNLOCK2}, CMD_UNLOCK2);
    u_fcs_cpu_model.wr(ad, c);
  endtask
  task automatic prog(input logic [15:0] ad, input logic [7:0] dt);
    u_fcs_cpu_model.cmd(CMD_PROG);
    u_fcs_cpu_model.wr(ad, dt);
  endtask
  // Launch check plus two polls: first toggle reads one, then it inverts
  task automatic tog(input logic [15:0] ad);
    #1;
    chk(b(busy), 8'h01);
    fr(ad, 1'b0);
    chk(b(d[TOGGLE_BIT]), 8'h01);
    fr(ad, 1'b0);
    chk(b(d[TOGGLE_BIT]), 8'h00);
  endtask
  task automatic idle(input int lim);
    n = 0;
    while (busy === 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    #1;
  endtask
  task automatic irqp(input logic v);
    @(posedge clk);
    irq  <= 1'b1;
    vram <= v;
    @(posedge clk);
    irq  <= 1'b0;
    #1;
    chk(b(vfr), b(v));
  endtask
  task automatic results();
    $display("checked %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    results();
  end
  initial begin
    {rst, rwr, rrd, xram, irq, vram, par, sclk} = 8'h80;
    {boot, radr, rwd, pin} = {1'b1, 28'h0};
    n_errors = 0;
    samples_checked = 0;
    void'($urandom(32'h174f));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rr(OFS_PORTGATE);
    chk(d, GATE_RESET);
    gate(8'h00, 8'h00, 1'b0);
    gate(8'h02, 8'hff, 1'b0);
    gate(8'h01, 8'h00, 1'b1);
    @(posedge clk);
    boot <= 1'b0;
    gate(8'h00, 8'hff, 1'b1);
    rr(OFS_PORTGATE);
    chk(d, 8'h00);
    rw(OFS_CTRL1, {MODE_ENABLE, 5'h0});
    rw(OFS_COMMIT, 8'hd4);
    #1;
    chk(b(exen), 8'h00);
    rw(OFS_COMMIT, COMMIT_KEY);
    rr(OFS_STATUS);
    chk(d, 8'h04);
    chk(b(exen), 8'h01);
    a = {4'h8, 12'($urandom)};
    @(posedge clk);
    par <= 1'b1;
    erase(a, CMD_SECTOR);
    #1;
    chk(b(busy), 8'h00);
    @(posedge clk);
    par <= 1'b0;
    erase(a, CMD_SECTOR);
    tog(a);
    prog(16'h8010, 8'h00);
    idle(5000);
    chk(b(n < 4200), 8'h01);
    fr(16'h8010, 1'b0);
    chk(d, ERASED_BYTE);
    fr(a, 1'b0);
    chk(d, ERASED_BYTE);
    pd = 8'($urandom);
    prog(a, pd);
    tog(a);
    idle(600);
    chk(b(n <= PROG_CYC), 8'h01);
    fr(a, 1'b0);
    chk(d, pd);
    u_fcs_cpu_model.cmd(CMD_ID_ENTRY);
    fr(ADDR_VENDOR, 1'b0);
    chk(d, VEND);
    fr(ADDR_FLASHID, 1'b0);
    chk(d, DEVC);
    fr(ADDR_SECURE, 1'b0);
    chk(d, SECURE_OFF);
    u_fcs_cpu_model.wr(16'h1234, CMD_ID_EXIT);
    fr(a, 1'b0);
    chk(d, pd);
    u_fcs_cpu_model.cmd(CMD_SECURE);
    u_fcs_cpu_model.wr(ADDR_SECURE, SECURE_DATA);
    tog(a);
    idle(600);
    u_fcs_cpu_model.cmd(CMD_ID_ENTRY);
    fr(ADDR_SECURE, 1'b0);
    chk(d, SECURE_DATA);
    u_fcs_cpu_model.wr(16'hf000, CMD_ID_EXIT);
    erase({4'hf, ADDR_UNLOCK1}, CMD_CHIP);
    tog(a);
    idle(34000);
    chk(b(n < 33000), 8'h01);
    fr(a, 1'b0);
    chk(d, ERASED_BYTE);
    u_fcs_cpu_model.cmd(CMD_ID_ENTRY);
    fr(ADDR_SECURE, 1'b0);
    chk(d, SECURE_OFF);
    u_fcs_cpu_model.wr(16'hf000, CMD_ID_EXIT);
    rw(OFS_CTRL1, {MODE_DISABLE, 5'h0});
    rw(OFS_COMMIT, COMMIT_KEY);
    prog(a ^ 16'h0001, 8'h00);
    #1;
    chk(b(busy | exen), 8'h00);
    fr(a ^ 16'h0001, 1'b0);
    chk(d, ERASED_BYTE);
    rw(OFS_STANDBY, 8'h01);
    fr(a, 1'b1);
    chk(b(srst), 8'h00);
    @(posedge clk);
    xram <= 1'b1;
    rw(OFS_STANDBY, 8'h01);
    fr(a, 1'b1);
    chk(b(srst), 8'h01);
    irqp(1'b1);
    fr(a, 1'b0);
    chk(b(srst), 8'h01);
    irqp(1'b0);
    fr(a, 1'b0);
    chk(b(srst), 8'h00);
    rw(OFS_STANDBY, 8'h00);
    results();
  end
endmodule
`default_nettype wire
